// File: pasu_add_core.sv
`timescale 1ns/1ps
// combinational add/subtract with overflow or carry flag
module pasu_add_core #(
  parameter int W      = 8,
  parameter bit SIGNED = 1'b1
) (
  // operands
  input  wire logic [W-1:0] opA,
  input  wire logic [W-1:0] opB,
  input  wire logic         carryIn,
  input  wire logic         doAdd,
  // result
  output logic      [W-1:0] sum,
  output logic              flag
);
  logic [W-1:0] bEff;
  logic [W:0]   wide;

  // subtract as a plus inverted b plus carry: a - b + cin - 1
  always_comb begin
    bEff = doAdd ? opB : ~opB;
    wide = {1'b0, opA} + {1'b0, bEff} + {{W{1'b0}}, carryIn};
    sum  = wide[W-1:0];
    if (SIGNED) begin
      // same-sign inputs giving other-sign result
      flag = (opA[W-1] == bEff[W-1]) && (wide[W-1] != opA[W-1]);
    end else begin
      // carry out; on subtract this is the inverted borrow
      flag = wide[W];
    end
  end
endmodule // pasu_add_core

// File: pasu_axil_slave.sv
`timescale 1ns/1ps
// axi4-lite slave: one write and one read in flight
module pasu_axil_slave
  import pasu_pkg::*;
(
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  // bus
  input  wire pasu_pkg::pasu_axi_req_s       axiReq,
  output pasu_pkg::pasu_axi_rsp_s            axiRsp,
  // register file side
  output logic                               wrFire,
  output logic [pasu_pkg::AXI_ADDR_W-1:0]    wrAddr,
  output logic [pasu_pkg::AXI_DATA_W-1:0]    wrData,
  output logic [3:0]                         wrStrb,
  input  wire logic                          wrErr,
  output logic [pasu_pkg::AXI_ADDR_W-1:0]    rdAddr,
  input  wire logic [pasu_pkg::AXI_DATA_W-1:0] rdData,
  input  wire logic                          rdErr
);
  typedef struct packed {
    logic                  awHeld;
    logic                  wHeld;
    logic [AXI_ADDR_W-1:0] awAddr;
    logic [AXI_DATA_W-1:0] wData;
    logic [3:0]            wStrb;
    logic                  bValid;
    logic [1:0]            bResp;
    logic                  arHeld;
    logic [AXI_ADDR_W-1:0] arAddr;
    logic                  rValid;
    logic [AXI_DATA_W-1:0] rData;
    logic [1:0]            rResp;
    logic                  awRdy;
    logic                  wRdy;
    logic                  arRdy;
  } pasu_slv_s;

  pasu_slv_s st_reg;
  pasu_slv_s st_next;

  // channel handshakes and response generation
  always_comb begin
    st_next = st_reg;
    wrFire  = 1'b0;
    if (axiReq.awvalid && st_reg.awRdy) begin
      st_next.awHeld = 1'b1;
      st_next.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && st_reg.wRdy) begin
      st_next.wHeld = 1'b1;
      st_next.wData = axiReq.wdata;
      st_next.wStrb = axiReq.wstrb;
    end
    if (st_reg.awHeld && st_reg.wHeld && !st_reg.bValid) begin
      wrFire         = 1'b1;
      st_next.awHeld = 1'b0;
      st_next.wHeld  = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp  = wrErr ? RESP_SLVERR : RESP_OKAY;
    end
    if (st_reg.bValid && axiReq.bready) begin
      st_next.bValid = 1'b0;
    end
    if (axiReq.arvalid && st_reg.arRdy) begin
      st_next.arHeld = 1'b1;
      st_next.arAddr = axiReq.araddr;
    end
    if (st_reg.arHeld && !st_reg.rValid) begin
      st_next.arHeld = 1'b0;
      st_next.rValid = 1'b1;
      st_next.rData  = rdErr ? '0 : rdData;
      st_next.rResp  = rdErr ? RESP_SLVERR : RESP_OKAY;
    end
    if (st_reg.rValid && axiReq.rready) begin
      st_next.rValid = 1'b0;
    end
    st_next.awRdy = !st_next.awHeld && !st_next.bValid;
    st_next.wRdy  = !st_next.wHeld && !st_next.bValid;
    st_next.arRdy = !st_next.arHeld && !st_next.rValid;
    if (!reset_n) begin
      st_next = '0;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    st_reg <= st_next;
  end

  // outputs straight from state
  assign wrAddr         = st_reg.awAddr;
  assign wrData         = st_reg.wData;
  assign wrStrb         = st_reg.wStrb;
  assign rdAddr         = st_reg.arAddr;
  assign axiRsp.awready = st_reg.awRdy;
  assign axiRsp.wready  = st_reg.wRdy;
  assign axiRsp.bvalid  = st_reg.bValid;
  assign axiRsp.bresp   = st_reg.bResp;
  assign axiRsp.arready = st_reg.arRdy;
  assign axiRsp.rvalid  = st_reg.rValid;
  assign axiRsp.rdata   = st_reg.rData;
  assign axiRsp.rresp   = st_reg.rResp;
endmodule // pasu_axil_slave

// File: pasu_feed_model.sv
`timescale 1ns/1ps
// upstream datapath neighbour: registers one operand set per clock
module pasu_feed_model #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  // operand set from the bench
  input  wire logic [W-1:0] aIn,
  input  wire logic [W-1:0] bIn,
  input  wire logic         cIn,
  input  wire logic         sIn,
  // operands toward the unit
  output logic      [W-1:0] opA,
  output logic      [W-1:0] opB,
  output logic              carryIn,
  output logic              addSel
);
  // select always driven to a defined level
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      {opA, opB, carryIn, addSel} <= '0;
    end else begin
      opA     <= aIn;
      opB     <= bIn;
      carryIn <= cIn;
      addSel  <= sIn === 1'b1;
    end
  end
endmodule // pasu_feed_model

// File: pasu_pkg.sv
// shared constants and carriers for the pipelined add/sub unit
package pasu_pkg;

  // register bus geometry
  localparam int          AXI_ADDR_W  = 8;
  localparam int          AXI_DATA_W  = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // register byte offsets
  localparam logic [AXI_ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFF_RESULT = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFF_FLAG   = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] OFF_COUNT  = 8'h0c;
  localparam logic [AXI_ADDR_W-1:0] OFF_CONFIG = 8'h10;

  // control register fields and reset value
  localparam int          CTRL_FREEZE_BIT = 0;
  localparam int          CTRL_SNAP_BIT   = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;

  // flag register fields
  localparam int FLAG_OUT_BIT = 0;
  localparam int FLAG_DIR_BIT = 1;

  // configuration readback fields
  localparam int CFG_STAGES_LSB = 0;
  localparam int CFG_INT_LSB    = 8;
  localparam int CFG_FRAC_LSB   = 16;
  localparam int CFG_TYPE_LSB   = 24;
  localparam int CFG_OPT_LSB    = 26;

  // operand number formats
  typedef enum logic [1:0] {
    PASU_SIGNED_INT  = 2'h0,
    PASU_SIGNED_FRAC = 2'h1,
    PASU_UNSIGNED    = 2'h2
  } pasu_bus_e;

  // fixed direction when no direction port is built
  typedef enum logic {
    PASU_DIR_SUB = 1'b0,
    PASU_DIR_ADD = 1'b1
  } pasu_dir_e;

  // axi4-lite master to slave
  typedef struct packed {
    logic [AXI_ADDR_W-1:0] awaddr;
    logic                  awvalid;
    logic [AXI_DATA_W-1:0] wdata;
    logic [3:0]            wstrb;
    logic                  wvalid;
    logic                  bready;
    logic [AXI_ADDR_W-1:0] araddr;
    logic                  arvalid;
    logic                  rready;
  } pasu_axi_req_s;

  // axi4-lite slave to master
  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
  } pasu_axi_rsp_s;

endpackage

// File: pasu_top.sv
// Behaviour
// - with select high, result is a plus b plus carry in.
// - with select low, result is a minus b plus carry in minus one.
// - flag is signed overflow for signed formats, carry out for unsigned.
// - unsigned subtract flag reads one when no borrow occurs.
// - with direction port built, one adds and zero subtracts; driver holds level.
// - without direction port, a build parameter fixes add or subtract.
// - build-set count of pipeline stages; zero gives a combinational path.
// - clock enable used only when built; otherwise the pipeline advances unless the control freeze bit is set.
// - asynchronous clear used only when built.
// - carry input used only when built; otherwise carry is zero.
// - flag output generated only when built; otherwise it reads zero.
// - bus format is signed integer, signed fractional or unsigned integer.
// - fraction bits may be nonzero only with the signed fractional format.
// - signed formats treat the top bit of operands and result as sign.
// - result has the operand widths, not widened for the carry.
// - integer formats have zero fraction bits; width equals integer width.
`timescale 1ns/1ps
module pasu_top
  import pasu_pkg::*;
#(
  parameter pasu_pkg::pasu_bus_e BUS_TYPE     = pasu_pkg::PASU_SIGNED_INT,
  parameter int                  INT_BITS     = 8,
  parameter int                  FRAC_BITS    = 0,
  parameter int                  PIPE_STAGES  = 1,
  parameter bit                  USE_ENA      = 1'b0,
  parameter bit                  USE_ACLR     = 1'b0,
  parameter bit                  USE_CIN      = 1'b0,
  parameter bit                  USE_FLAG     = 1'b0,
  parameter bit                  USE_DIR_PORT = 1'b0,
  parameter pasu_pkg::pasu_dir_e FIXED_DIR    = pasu_pkg::PASU_DIR_ADD
) (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  // operands and controls
  input  wire logic [INT_BITS+FRAC_BITS-1:0] opA,
  input  wire logic [INT_BITS+FRAC_BITS-1:0] opB,
  input  wire logic                         carryIn,
  input  wire logic                         addSel,
  input  wire logic                         clkEn,
  input  wire logic                         asyncClr,
  // results
  output logic [INT_BITS+FRAC_BITS-1:0]      result,
  output logic                              flagOut,
  // register bus
  input  wire pasu_pkg::pasu_axi_req_s      axiReq,
  output pasu_pkg::pasu_axi_rsp_s           axiRsp
);
  import pasu_pkg::*;

  // widths; result keeps the operand width
  localparam int W     = INT_BITS + FRAC_BITS;
  localparam int DEPTH = (PIPE_STAGES > 0) ? PIPE_STAGES : 1;
  localparam bit IS_SIGNED = (BUS_TYPE != PASU_UNSIGNED);

  // build-time checks
  if (W < 1 || W > AXI_DATA_W) begin : g_badWidth
    $error("operand width must be 1 to 32 bits");
  end
  if (INT_BITS < 0 || FRAC_BITS < 0) begin : g_badBits
    $error("bit counts must not be negative");
  end
  if (FRAC_BITS != 0 && BUS_TYPE != PASU_SIGNED_FRAC) begin : g_badFrac
    $error("fraction bits need the signed fractional format");
  end
  if (PIPE_STAGES < 0 || PIPE_STAGES > 255) begin : g_badStages
    $error("pipeline stages must be 0 to 255");
  end
  if (BUS_TYPE != PASU_SIGNED_INT && BUS_TYPE != PASU_SIGNED_FRAC
      && BUS_TYPE != PASU_UNSIGNED) begin : g_badType
    $error("unknown bus format");
  end

  // configuration word readable by software
  localparam logic [4:0] CFG_OPTS = {USE_DIR_PORT, USE_FLAG, USE_CIN, USE_ACLR, USE_ENA};
  localparam logic [AXI_DATA_W-1:0] CFG_WORD =
      (AXI_DATA_W'(PIPE_STAGES) << CFG_STAGES_LSB)
    | (AXI_DATA_W'(INT_BITS)    << CFG_INT_LSB)
    | (AXI_DATA_W'(FRAC_BITS)   << CFG_FRAC_LSB)
    | (AXI_DATA_W'(BUS_TYPE)    << CFG_TYPE_LSB)
    | (AXI_DATA_W'(CFG_OPTS)    << CFG_OPT_LSB);

  typedef struct packed {
    logic                      freeze;
    logic                      snapEn;
    logic [AXI_DATA_W-1:0]     count;
    logic [W-1:0]              snapRes;
    logic                      snapFlag;
    logic [DEPTH-1:0][W-1:0]   pipeRes;
    logic [DEPTH-1:0]          pipeFlag;
  } pasu_main_s;

  pasu_main_s st_reg;
  pasu_main_s st_next;

  // address map membership, shared by read and write decode
  function automatic logic isMapped(input logic [AXI_ADDR_W-1:0] addr);
    return (addr == OFF_CTRL) || (addr == OFF_RESULT) || (addr == OFF_FLAG)
        || (addr == OFF_COUNT) || (addr == OFF_CONFIG);
  endfunction

  // option gating of the optional inputs
  logic opAdd;
  logic cinEff;
  logic clrAsync;
  logic advance;

  assign opAdd    = USE_DIR_PORT ? addSel : (FIXED_DIR == PASU_DIR_ADD);
  assign cinEff   = USE_CIN ? carryIn : 1'b0;
  assign clrAsync = USE_ACLR ? asyncClr : 1'b0;
  assign advance  = (USE_ENA ? clkEn : 1'b1) && !st_reg.freeze;

  // arithmetic core
  logic [W-1:0] coreSum;
  logic         coreFlag;

  pasu_add_core #(
    .W      (W),
    .SIGNED (IS_SIGNED)
  ) u_core (
    .opA     (opA),
    .opB     (opB),
    .carryIn (cinEff),
    .doAdd   (opAdd),
    .sum     (coreSum),
    .flag    (coreFlag)
  );

  // register bus slave
  logic                  wrFire;
  logic [AXI_ADDR_W-1:0] wrAddr;
  logic [AXI_DATA_W-1:0] wrData;
  logic [3:0]            wrStrb;
  logic [AXI_ADDR_W-1:0] rdAddr;
  logic [AXI_DATA_W-1:0] rdData;
  logic                  wrErr;
  logic                  rdErr;

  pasu_axil_slave u_slave (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .axiReq  (axiReq),
    .axiRsp  (axiRsp),
    .wrFire  (wrFire),
    .wrAddr  (wrAddr),
    .wrData  (wrData),
    .wrStrb  (wrStrb),
    .wrErr   (wrErr),
    .rdAddr  (rdAddr),
    .rdData  (rdData),
    .rdErr   (rdErr)
  );

  // pipeline output taps; zero stages bypasses the registers
  logic [W-1:0] pipeOut;
  logic         pipeFlagOut;

  assign pipeOut     = (PIPE_STAGES == 0) ? coreSum : st_reg.pipeRes[DEPTH-1];
  assign pipeFlagOut = (PIPE_STAGES == 0) ? coreFlag : st_reg.pipeFlag[DEPTH-1];

  // read decode and unmapped answers
  always_comb begin
    wrErr  = !isMapped(wrAddr);
    rdErr  = !isMapped(rdAddr);
    rdData = '0;
    case (rdAddr)
      OFF_CTRL: begin
        rdData[CTRL_FREEZE_BIT] = st_reg.freeze;
        rdData[CTRL_SNAP_BIT]   = st_reg.snapEn;
      end
      OFF_RESULT: begin
        rdData[W-1:0] = st_reg.snapRes;
      end
      OFF_FLAG: begin
        rdData[FLAG_OUT_BIT] = st_reg.snapFlag;
        rdData[FLAG_DIR_BIT] = opAdd;
      end
      OFF_COUNT: begin
        rdData = st_reg.count;
      end
      OFF_CONFIG: begin
        rdData = CFG_WORD;
      end
      default: begin
        rdData = '0;
      end
    endcase
  end

  // next state: pipeline shift, snapshot, counter, control writes
  always_comb begin
    st_next = st_reg;
    if (advance) begin
      st_next.pipeRes[0]  = coreSum;
      st_next.pipeFlag[0] = USE_FLAG ? coreFlag : 1'b0;
      for (int i = 1; i < DEPTH; i++) begin
        st_next.pipeRes[i]  = st_reg.pipeRes[i-1];
        st_next.pipeFlag[i] = st_reg.pipeFlag[i-1];
      end
      st_next.count = st_reg.count + 32'h1;
    end
    if (st_reg.snapEn) begin
      st_next.snapRes  = pipeOut;
      st_next.snapFlag = USE_FLAG ? pipeFlagOut : 1'b0;
    end
    if (wrFire && wrAddr == OFF_CTRL && wrStrb[0]) begin
      st_next.freeze = wrData[CTRL_FREEZE_BIT];
      st_next.snapEn = wrData[CTRL_SNAP_BIT];
    end
    if (!reset_n) begin
      st_next        = '0;
      st_next.freeze = CTRL_RESET[CTRL_FREEZE_BIT];
      st_next.snapEn = CTRL_RESET[CTRL_SNAP_BIT];
    end
  end

  // state register with optional asynchronous clear
  always_ff @(posedge ref_clk or posedge clrAsync) begin
    if (clrAsync) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // datapath outputs
  assign result  = pipeOut;
  assign flagOut = USE_FLAG ? pipeFlagOut : 1'b0;
endmodule // pasu_top

// File: pasu_top_sva.sv
`timescale 1ns/1ps
// port checker for the add/sub unit
module pasu_top_sva
  import pasu_pkg::*;
#(
  parameter pasu_pkg::pasu_bus_e BUS_TYPE     = pasu_pkg::PASU_SIGNED_INT,
  parameter int                  INT_BITS     = 8,
  parameter int                  FRAC_BITS    = 0,
  parameter int                  PIPE_STAGES  = 1,
  parameter bit                  USE_ENA      = 1'b0,
  parameter bit                  USE_ACLR     = 1'b0,
  parameter bit                  USE_CIN      = 1'b0,
  parameter bit                  USE_FLAG     = 1'b0,
  parameter bit                  USE_DIR_PORT = 1'b0,
  parameter pasu_pkg::pasu_dir_e FIXED_DIR    = pasu_pkg::PASU_DIR_ADD
) (
  // clock and reset
  input wire logic                          ref_clk,
  input wire logic                          reset_n,
  // datapath
  input wire logic [INT_BITS+FRAC_BITS-1:0] opA,
  input wire logic [INT_BITS+FRAC_BITS-1:0] opB,
  input wire logic                          carryIn,
  input wire logic                          addSel,
  input wire logic                          clkEn,
  input wire logic                          asyncClr,
  input wire logic [INT_BITS+FRAC_BITS-1:0] result,
  input wire logic                          flagOut,
  // register bus
  input wire pasu_pkg::pasu_axi_req_s       axiReq,
  input wire pasu_pkg::pasu_axi_rsp_s       axiRsp
);
  localparam int W = INT_BITS + FRAC_BITS;
  logic       frzReg;
  logic [2:0] idleReg;
  logic       quiet;
  logic       enOn;

  // enable as the unit sees it; unbuilt enable always advances
  assign enOn = clkEn || !USE_ENA;

  // reference result with its flag above it
  function automatic logic [W:0] calc(logic [W-1:0] a, logic [W-1:0] b, logic c, logic s);
    logic [W-1:0] be;
    logic [W:0]   f;
    be = (USE_DIR_PORT ? s : FIXED_DIR) ? b : ~b;
    f = {1'b0, a} + {1'b0, be} + (W+1)'(USE_CIN & c);
    return {USE_FLAG & (BUS_TYPE == PASU_UNSIGNED ? f[W] : a[W-1] == be[W-1] && f[W-1] != a[W-1]), f[W-1:0]};
  endfunction

  // freeze tracking, quiet once no write seen for a while
  always_ff @(posedge ref_clk) begin
    if (!reset_n || (USE_ACLR && asyncClr)) begin
      frzReg  <= 1'b0;
      idleReg <= 3'h0;
    end else begin
      if (axiReq.awvalid && axiReq.wvalid && axiReq.awaddr == OFF_CTRL && axiReq.wstrb[0]) begin
        frzReg <= axiReq.wdata[0];
      end
      idleReg <= axiReq.awvalid ? 3'h0 : idleReg + {2'h0, idleReg != 3'h7};
    end
  end
  assign quiet = !frzReg && idleReg == 3'h7;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n || (USE_ACLR && asyncClr));

  property p_add;
    PIPE_STAGES == 1 && quiet && enOn && addSel |=> result == W'(calc($past(opA), $past(opB), $past(carryIn), 1'b1));
  endproperty
  a_add: assert property (p_add) else $error("sum wrong");
  property p_sub;
    PIPE_STAGES == 1 && quiet && enOn && !addSel |=> result == W'(calc($past(opA), $past(opB), $past(carryIn), 1'b0));
  endproperty
  a_sub: assert property (p_sub) else $error("difference wrong");
  property p_flag;
    PIPE_STAGES == 1 && quiet && enOn |=> {flagOut, result} == calc($past(opA), $past(opB), $past(carryIn), $past(addSel));
  endproperty
  a_flag: assert property (p_flag) else $error("flag wrong");
  property p_hold;
    PIPE_STAGES > 0 && !enOn |=> $stable(result) && $stable(flagOut);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved while disabled");
  property p_clr;
    disable iff (!reset_n) USE_ACLR && PIPE_STAGES > 0 && asyncClr |-> result == '0 && !flagOut;
  endproperty
  a_clr: assert property (p_clr) else $error("clear did not zero");
  property p_comb;
    PIPE_STAGES == 0 && quiet |-> {flagOut, result} == calc(opA, opB, carryIn, addSel);
  endproperty
  a_comb: assert property (p_comb) else $error("combinational path wrong");
  property p_usub;
    BUS_TYPE == PASU_UNSIGNED && PIPE_STAGES == 0 && USE_FLAG && USE_CIN && USE_DIR_PORT && quiet && !addSel
      |-> flagOut == (carryIn ? opA >= opB : opA > opB);
  endproperty
  a_usub: assert property (p_usub) else $error("borrow flag wrong");
  property p_sign;
    BUS_TYPE != PASU_UNSIGNED && PIPE_STAGES == 1 && USE_FLAG && USE_DIR_PORT && quiet && enOn && addSel
      && opA[W-1] == opB[W-1] |=> flagOut == (result[W-1] != $past(opA[W-1]));
  endproperty
  a_sign: assert property (p_sign) else $error("sign overflow wrong");
endmodule // pasu_top_sva

bind pasu_top pasu_top_sva #(
  .BUS_TYPE(BUS_TYPE), .INT_BITS(INT_BITS), .FRAC_BITS(FRAC_BITS), .PIPE_STAGES(PIPE_STAGES),
  .USE_ENA(USE_ENA), .USE_ACLR(USE_ACLR),
  .USE_CIN(USE_CIN), .USE_FLAG(USE_FLAG), .USE_DIR_PORT(USE_DIR_PORT), .FIXED_DIR(FIXED_DIR)
) chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .opA(opA), .opB(opB), .carryIn(carryIn), .addSel(addSel),
  .clkEn(clkEn), .asyncClr(asyncClr), .result(result), .flagOut(flagOut), .axiReq(axiReq), .axiRsp(axiRsp)
);

// File: pipelined_add_sub_unit_tb.sv
`timescale 1ns/1ps
// self-checking bench for the add/sub unit
module pipelined_add_sub_unit_tb;
  import pasu_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [1:0] cs;
    logic [7:0] r;
    logic [1:0] fsu;
  } pasu_row_s;
  logic          ref_clk = 1'b0;
  logic          reset_n = 1'b0;
  logic [7:0]    aIn = 8'h00, bIn = 8'h00, opA, opB, result, resU;
  logic          cIn = 1'b0, sIn = 1'b0, carryIn, addSel, flagOut, flgU;
  logic          clkEn = 1'b1, asyncClr = 1'b0;
  pasu_axi_req_s req = '0;
  pasu_axi_rsp_s rsp;
  logic [31:0]   d;
  logic [1:0]    rs;
  int            errors = 0, checksDone = 0;
  // a, b, {cin,add}, result, {signed flag,unsigned flag}
  pasu_row_s     rows [8] = '{'{8'h7f, 8'h01, 2'h1, 8'h80, 2'h2}, '{8'hff, 8'h01, 2'h3, 8'h01, 2'h1},
    '{8'h80, 8'h01, 2'h2, 8'h7f, 2'h3}, '{8'h05, 8'h05, 2'h0, 8'hff, 2'h0}, '{8'h03, 8'h07, 2'h2, 8'hfc, 2'h0},
    '{8'h80, 8'h80, 2'h1, 8'h00, 2'h3}, '{8'h12, 8'h34, 2'h3, 8'h47, 2'h0}, '{8'h40, 8'hc0, 2'h2, 8'h80, 2'h2}};

  always #25 ref_clk = ~ref_clk;

  // build choices for the feed model and both units
  localparam int OPW   = 8;
  localparam int PIPED = 1;
  localparam int COMB  = 0;
  localparam bit OPT   = 1'b1;

  // upstream neighbour and two builds of the unit
  pasu_feed_model #(.W(OPW)) feed (.ref_clk(ref_clk), .reset_n(reset_n), .aIn(aIn), .bIn(bIn), .cIn(cIn),
    .sIn(sIn), .opA(opA), .opB(opB), .carryIn(carryIn), .addSel(addSel));
  pasu_top #(.BUS_TYPE(PASU_SIGNED_INT), .PIPE_STAGES(PIPED), .USE_ENA(OPT), .USE_ACLR(OPT), .USE_CIN(OPT),
    .USE_FLAG(OPT), .USE_DIR_PORT(OPT)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .opA(opA), .opB(opB),
    .carryIn(carryIn), .addSel(addSel), .clkEn(clkEn), .asyncClr(asyncClr), .result(result),
    .flagOut(flagOut), .axiReq(req), .axiRsp(rsp));
  pasu_top #(.BUS_TYPE(PASU_UNSIGNED), .PIPE_STAGES(COMB), .USE_ENA(OPT), .USE_ACLR(OPT), .USE_CIN(OPT),
    .USE_FLAG(OPT), .USE_DIR_PORT(OPT)) dutU (.ref_clk(ref_clk), .reset_n(reset_n), .opA(opA), .opB(opB),
    .carryIn(carryIn), .addSel(addSel), .clkEn(clkEn), .asyncClr(asyncClr), .result(resU),
    .flagOut(flgU), .axiReq(req), .axiRsp());

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic results;
    if (errors == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // bus write, address and data offered together
  task automatic axw(input logic [7:0] ad, input logic [31:0] wd, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    {req.awaddr, req.wdata, req.wstrb} <= {ad, wd, 4'hf};
    {req.awvalid, req.wvalid, req.bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 64);
    req.bready <= 1'b0;
    r = rsp.bresp;
    if (n >= 64) begin
      errors++;
      results();
    end
  endtask

  // bus read
  task automatic axr(input logic [7:0] ad, output logic [31:0] rd, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    {req.araddr, req.arvalid, req.rready} <= {ad, 2'h3};
    do begin
      @(posedge ref_clk);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 64);
    req.rready <= 1'b0;
    {rd, r} = {rsp.rdata, rsp.rresp};
    if (n >= 64) begin
      errors++;
      results();
    end
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    // table streamed back to back; outputs trail by feed and pipe
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      if (i < 8) {aIn, bIn, cIn, sIn} <= {rows[i].a, rows[i].b, rows[i].cs};
      #5;
      if (i >= 2) chk({rows[i-2].fsu[1], rows[i-2].r}, {flagOut, result});
      if (i >= 1 && i < 9) chk({rows[i-1].fsu[0], rows[i-1].r}, {flgU, resU});
    end
    @(posedge ref_clk);
    {clkEn, aIn, bIn, cIn, sIn} <= {1'b0, 8'h01, 8'h01, 2'h1};
    repeat (3) @(posedge ref_clk);
    #5 chk({rows[7].fsu[1], rows[7].r}, {flagOut, result});
    @(posedge ref_clk);
    clkEn <= 1'b1;
    @(posedge ref_clk);
    #5 chk(32'h002, {flagOut, result});
    // registers: configuration, unmapped place, read-only, freeze
    axr(OFF_CONFIG, d, rs);
    chk(32'h7c000801, d);
    axr(8'h14, d, rs);
    chk({30'h0, RESP_SLVERR}, {d[29:0], rs});
    axw(OFF_RESULT, 32'hffffffff, rs);
    chk({30'h0, RESP_OKAY}, {30'h0, rs});
    axw(OFF_CTRL, 32'h1, rs);
    aIn <= 8'h20;
    repeat (4) @(posedge ref_clk);
    #5 chk(32'h002, {flagOut, result});
    axw(OFF_CTRL, 32'h0, rs);
    repeat (2) @(posedge ref_clk);
    #5 chk(32'h021, {flagOut, result});
    // snapshot registers: result copy, flag copy and current direction
    axw(OFF_CTRL, 32'h2, rs);
    axr(OFF_RESULT, d, rs);
    chk(32'h21, d);
    axr(OFF_FLAG, d, rs);
    chk(32'h2, d);
    // mid-run reset clears pipeline, control and counter
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #5 chk(32'h000, {flagOut, result});
    @(posedge ref_clk);
    reset_n <= 1'b1;
    axr(OFF_COUNT, d, rs);
    chk(32'h2, d);
    axr(OFF_CTRL, d, rs);
    chk(32'h0, d);
    @(posedge ref_clk);
    asyncClr <= 1'b1;
    #5 chk(32'h000, {flagOut, result});
    @(posedge ref_clk);
    asyncClr <= 1'b0;
    results();
  end
endmodule // pipelined_add_sub_unit_tb
